/* File: rtl/gpio_port_pkg.sv */
package gpio_port_pkg;

   // ****************************************
   // Register offsets (byte addresses)
   // ****************************************
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_PIN_DATA = 8'h00;
   localparam logic [7:0] OFS_OUTPUT_ENABLE = 8'h04;
   localparam logic [7:0] OFS_FUNCTION_SELECT = 8'h08;
   localparam logic [7:0] OFS_OPEN_DRAIN = 8'h28;
   localparam logic [7:0] OFS_PULLUP_ENABLE = 8'h2c;
   localparam logic [7:0] OFS_PULLDOWN_ENABLE = 8'h30;
   localparam logic [7:0] OFS_INPUT_ENABLE = 8'h38;
   localparam logic [7:0] OFS_STANDBY_CONTROL = 8'h40;

   // ****************************************
   // Reset values and implemented-bit masks
   // ****************************************
   localparam logic [7:0] RST_PIN_DATA = 8'h00;
   localparam logic [7:0] RST_OUTPUT_ENABLE = 8'h01;
   localparam logic [7:0] RST_FUNCTION_SELECT = 8'h03;
   localparam logic [7:0] RST_OPEN_DRAIN = 8'h00;
   localparam logic [7:0] RST_PULLUP_ENABLE = 8'h01;
   localparam logic [7:0] RST_PULLDOWN_ENABLE = 8'h02;
   localparam logic [7:0] RST_INPUT_ENABLE = 8'h03;
   localparam logic RST_DRIVE_ENABLE = 1'b0;
   localparam logic [7:0] MASK_FUNCTION_SELECT = 8'h7f;
   localparam logic [7:0] MASK_PULLUP_ENABLE = 8'hfd;
   localparam logic [7:0] MASK_PULLDOWN_ENABLE = 8'h02;

   // Standby control fields
   localparam int DRIVE_ENABLE_BIT = 0;
   localparam int STOP_MODE_BIT = 1;

   // Pin roles
   localparam int DEBUG_DATA_PIN = 0;
   localparam int DEBUG_CLOCK_PIN = 1;

endpackage

/* File: rtl/gpio_port_pin_config.sv */
`timescale 1ns/1ps
// How it works
// - Data register: read pins, write output values
// - Separate per-bit output and input gates
// - Function bit one routes peripheral function
// - Open-drain bit one disables output buffer
// - Per-bit pull-up enable register, bit 1 not implemented
// - Pull-down enable register, bit 1 only
// - Inputs disabled after reset except debug
// - Stop with drive enable keeps enables
// - Stop without drive enable kills I/O
// - Interrupt pins keep input in stop
// - Debug data output in stop only when valid
// - Eight-bit port, per-bit direction
// - Pins selectable for debug and trace
// - Bit 0 debug data, in/out/pull-up on
// - Bit 1 debug clock, input, pull-down
// - Bits 2-7 plain port, all disabled
// - Debug data output kept in stop while its data is valid
// - Registers at fixed port offsets
// - Control line true open-drain, no pull
module gpio_port_pin_config #(
   parameter int WIDTH = 8,
   parameter logic [7:0] IRQ_PIN_MASK = 8'h00
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   input wire logic stop_mode_i,
   input wire logic [WIDTH-1:0] periph_out_i,
   input wire logic [WIDTH-1:0] periph_oe_i,
   input wire logic debug_data_valid_i,
   output logic [WIDTH-1:0] periph_in_o,
   input wire logic [WIDTH-1:0] pin_i,
   output logic [WIDTH-1:0] pin_o,
   output logic [WIDTH-1:0] pin_oe_n_o,
   output logic [WIDTH-1:0] pin_pullup_o,
   output logic [WIDTH-1:0] pin_pulldown_o,
   output logic [WIDTH-1:0] pin_input_en_o,
   input wire logic control_line_i,
   output logic control_line_oe_n_o,
   output logic control_line_in_o
);

   // ****************************************
   // Elaboration checks
   // ****************************************
   if (WIDTH != 8) begin : g_width_check
      $error("gpio_port_pin_config supports an 8-bit port only");
   end

   // ****************************************
   // Registers
   // ****************************************
   logic [7:0] pin_data_reg;
   logic [7:0] output_enable_reg;
   logic [7:0] function_select_reg;
   logic [7:0] open_drain_reg;
   logic [7:0] pullup_enable_reg;
   logic [7:0] pulldown_enable_reg;
   logic [7:0] input_enable_reg;
   logic drive_enable_reg;
   logic control_drive_low_reg;
   logic [31:0] rdata_reg;
   logic [7:0] pin_meta_reg;
   logic [7:0] pin_sync_reg;
   logic ctl_meta_reg;
   logic ctl_sync_reg;
   logic [7:0] in_gate;
   logic [7:0] out_gate;
   logic [7:0] out_value;

   // Per-pin gating: normal, then stop-mode overrides
   genvar gi;
   for (gi = 0; gi < WIDTH; gi++) begin : g_pin
      logic use_func;
      logic oe_req;
      logic in_req;
      assign use_func = function_select_reg[gi];
      // Peripheral owns value and gates the enable when selected
      assign oe_req = output_enable_reg[gi] & ~open_drain_reg[gi]
                      & (use_func ? periph_oe_i[gi] : 1'b1);
      assign in_req = input_enable_reg[gi];
      assign out_value[gi] = use_func ? periph_out_i[gi] : pin_data_reg[gi];
      always_comb begin
         in_gate[gi] = in_req;
         out_gate[gi] = oe_req;
         if (stop_mode_i) begin
            if (drive_enable_reg) begin
               in_gate[gi] = in_req;
               out_gate[gi] = oe_req;
            end else begin
               in_gate[gi] = 1'b0;
               out_gate[gi] = 1'b0;
            end
            // Wake-up pins must stay listening in stop
            if (IRQ_PIN_MASK[gi] && use_func && in_req) begin
               in_gate[gi] = 1'b1;
            end
            // Debug data only drives while its data is valid
            if (gi == gpio_port_pkg::DEBUG_DATA_PIN && use_func && output_enable_reg[gi]) begin
               out_gate[gi] = oe_req & debug_data_valid_i;
            end
         end
      end
   end

   // ****************************************
   // Pin outputs
   // ****************************************
   // Output enable active low: low while driving
   assign pin_o = out_value;
   assign pin_oe_n_o = ~out_gate;
   assign pin_input_en_o = in_gate;
   assign pin_pullup_o = pullup_enable_reg;
   assign pin_pulldown_o = pulldown_enable_reg;
   assign periph_in_o = pin_sync_reg & in_gate;

   // Control line: never drives high, no pull
   assign control_line_oe_n_o = ~control_drive_low_reg;
   assign control_line_in_o = ctl_sync_reg;

   assign rdata_o = rdata_reg;

   // ****************************************
   // Input synchronisers
   // ****************************************
   // Pins are asynchronous; two stages before any use
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_meta_reg <= 8'h00;
         pin_sync_reg <= 8'h00;
         ctl_meta_reg <= 1'b1;
         ctl_sync_reg <= 1'b1;
      end else begin
         pin_meta_reg <= pin_i;
         pin_sync_reg <= pin_meta_reg;
         ctl_meta_reg <= control_line_i;
         ctl_sync_reg <= ctl_meta_reg;
      end
   end

   // ****************************************
   // Register writes
   // ****************************************
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_data_reg <= gpio_port_pkg::RST_PIN_DATA;
         output_enable_reg <= gpio_port_pkg::RST_OUTPUT_ENABLE;
         function_select_reg <= gpio_port_pkg::RST_FUNCTION_SELECT;
         open_drain_reg <= gpio_port_pkg::RST_OPEN_DRAIN;
         pullup_enable_reg <= gpio_port_pkg::RST_PULLUP_ENABLE;
         pulldown_enable_reg <= gpio_port_pkg::RST_PULLDOWN_ENABLE;
         input_enable_reg <= gpio_port_pkg::RST_INPUT_ENABLE;
         drive_enable_reg <= gpio_port_pkg::RST_DRIVE_ENABLE;
         control_drive_low_reg <= 1'b0;
      end else if (wr_i) begin
         case (addr_i)
            gpio_port_pkg::OFS_PIN_DATA: begin
               pin_data_reg <= wdata_i[7:0];
            end
            gpio_port_pkg::OFS_OUTPUT_ENABLE: begin
               output_enable_reg <= wdata_i[7:0];
            end
            gpio_port_pkg::OFS_FUNCTION_SELECT: begin
               function_select_reg <= wdata_i[7:0] & gpio_port_pkg::MASK_FUNCTION_SELECT;
            end
            gpio_port_pkg::OFS_OPEN_DRAIN: begin
               open_drain_reg <= wdata_i[7:0];
            end
            gpio_port_pkg::OFS_PULLUP_ENABLE: begin
               pullup_enable_reg <= wdata_i[7:0] & gpio_port_pkg::MASK_PULLUP_ENABLE;
            end
            gpio_port_pkg::OFS_PULLDOWN_ENABLE: begin
               pulldown_enable_reg <= wdata_i[7:0] & gpio_port_pkg::MASK_PULLDOWN_ENABLE;
            end
            gpio_port_pkg::OFS_INPUT_ENABLE: begin
               input_enable_reg <= wdata_i[7:0];
            end
            gpio_port_pkg::OFS_STANDBY_CONTROL: begin
               drive_enable_reg <= wdata_i[gpio_port_pkg::DRIVE_ENABLE_BIT];
               control_drive_low_reg <= wdata_i[gpio_port_pkg::STOP_MODE_BIT];
            end
            default: begin
            end
         endcase
      end
   end

   // ****************************************
   // Register reads, data one cycle later
   // ****************************************
   // Unmapped addresses read zero; the data register shows synced pin levels of input-enabled pins, others zero
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_reg <= 32'h0000_0000;
      end else if (rd_i) begin
         case (addr_i)
            gpio_port_pkg::OFS_PIN_DATA: begin
               rdata_reg <= {24'h00_0000, (pin_sync_reg & in_gate)};
            end
            gpio_port_pkg::OFS_OUTPUT_ENABLE: begin
               rdata_reg <= {24'h00_0000, output_enable_reg};
            end
            gpio_port_pkg::OFS_FUNCTION_SELECT: begin
               rdata_reg <= {24'h00_0000, function_select_reg};
            end
            gpio_port_pkg::OFS_OPEN_DRAIN: begin
               rdata_reg <= {24'h00_0000, open_drain_reg};
            end
            gpio_port_pkg::OFS_PULLUP_ENABLE: begin
               rdata_reg <= {24'h00_0000, pullup_enable_reg};
            end
            gpio_port_pkg::OFS_PULLDOWN_ENABLE: begin
               rdata_reg <= {24'h00_0000, pulldown_enable_reg};
            end
            gpio_port_pkg::OFS_INPUT_ENABLE: begin
               rdata_reg <= {24'h00_0000, input_enable_reg};
            end
            gpio_port_pkg::OFS_STANDBY_CONTROL: begin
               rdata_reg <= {30'h0000_0000, control_drive_low_reg, drive_enable_reg};
            end
            default: begin
               rdata_reg <= 32'h0000_0000;
            end
         endcase
      end else begin
         rdata_reg <= 32'h0000_0000;
      end
   end

endmodule

/* File: test/gpio_port_pin_config_assertions.sv */
`timescale 1ns/1ps
module gpio_port_pin_config_assertions #(
   parameter logic [7:0] IRQ_PIN_MASK = 8'h00
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [31:0] rdata_o,
   input wire logic stop_mode_i,
   input wire logic [7:0] periph_oe_i,
   input wire logic debug_data_valid_i,
   input wire logic [7:0] pin_oe_n_o,
   input wire logic [7:0] pin_pullup_o,
   input wire logic [7:0] pin_input_en_o
);
   logic [7:0] fsel_reg;
   logic de_reg;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   // ****************************************
   // Shadow of function select and drive enable
   // ****************************************
   // Rebuilt from bus writes, since the checker sees only ports
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fsel_reg <= gpio_port_pkg::RST_FUNCTION_SELECT;
         de_reg <= gpio_port_pkg::RST_DRIVE_ENABLE;
      end else if (wr_i && addr_i == gpio_port_pkg::OFS_FUNCTION_SELECT) begin
         fsel_reg <= wdata_i[7:0] & gpio_port_pkg::MASK_FUNCTION_SELECT;
      end else if (wr_i && addr_i == gpio_port_pkg::OFS_STANDBY_CONTROL) begin
         de_reg <= wdata_i[0];
      end
   end
   sequence pullup_wr_s;
      wr_i && addr_i == gpio_port_pkg::OFS_PULLUP_ENABLE;
   endsequence
   chk_rdata_idle: assert property (!rd_i |=> rdata_o == 32'h0000_0000)
      else $error("read data not idle");
   chk_rdata_upper: assert property (rd_i |=> rdata_o[31:8] == 24'h00_0000)
      else $error("read data upper bits set");
   // Pull-ups change only through their own register
   chk_pullup_hold: assert property (!(wr_i && addr_i == gpio_port_pkg::OFS_PULLUP_ENABLE) |=> $stable(pin_pullup_o))
      else $error("pull-up changed without write");
   chk_pullup_back: assert property (rd_i && addr_i == 8'h2c |=> rdata_o[7:0] == $past(pin_pullup_o))
      else $error("pull-up readback mismatch");
   chk_pullup_write: assert property (pullup_wr_s |=> pin_pullup_o == ($past(wdata_i[7:0]) & 8'hfd))
      else $error("pull-up write mismatch");
   chk_stop_off: assert property (stop_mode_i && !de_reg |-> (~pin_oe_n_o & 8'hfe) == 8'h00 && (pin_input_en_o & ~IRQ_PIN_MASK) == 8'h00)
      else $error("pin active in stop");
   chk_debug_valid: assert property (stop_mode_i && fsel_reg[0] && !debug_data_valid_i |-> pin_oe_n_o[0])
      else $error("debug pin drives without valid");
   chk_periph_gate: assert property ((~pin_oe_n_o & fsel_reg & ~periph_oe_i) == 8'h00)
      else $error("function pin drives without enable");
endmodule
bind gpio_port_pin_config gpio_port_pin_config_assertions #(.IRQ_PIN_MASK(IRQ_PIN_MASK)) chk (
   .sys_clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .stop_mode_i,
   .periph_oe_i, .debug_data_valid_i, .pin_oe_n_o, .pin_pullup_o, .pin_input_en_o);

/* File: test/board_pin_model.sv */
`timescale 1ns/1ps
module board_pin_model (
   input wire logic sys_clk_i,
   input wire logic [7:0] pin_o,
   input wire logic [7:0] pin_oe_n_o,
   input wire logic [7:0] pin_pullup_o,
   input wire logic [7:0] pin_pulldown_o,
   input wire logic control_line_oe_n_o,
   output logic [7:0] pin_i,
   output logic control_line_i
);
   logic [7:0] float_reg = 8'h55;
   // Floating pins wander so a stale value never looks right
   always_ff @(posedge sys_clk_i) float_reg <= ~float_reg;
   // Pad level: driver, then pull resistor, then nothing
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pin_i[i] = !pin_oe_n_o[i] ? pin_o[i] : pin_pullup_o[i] ? 1'b1 :
            pin_pulldown_o[i] ? 1'b0 : float_reg[i];
      end
   end
   // Line only pulled low, board pull-up otherwise
   assign control_line_i = control_line_oe_n_o;
endmodule

/* File: test/tb_gpio_port_pin_config.sv */
`timescale 1ns/1ps
module tb_gpio_port_pin_config;
   logic sys_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0000_0000;
   logic wr_i = 1'b0, rd_i = 1'b0, stop_mode_i = 1'b0, debug_data_valid_i = 1'b0;
   logic [7:0] periph_out_i = 8'h00, periph_oe_i = 8'h00;
   logic [31:0] rdata_o;
   logic [7:0] pin_i, pin_o, pin_oe_n_o, pin_pullup_o, pin_pulldown_o, pin_input_en_o;
   logic [7:0] periph_in_o;
   logic control_line_i, control_line_oe_n_o, control_line_in_o;
   logic [7:0] ofs [5] = '{8'h04, 8'h08, 8'h2c, 8'h30, 8'h38};
   logic [7:0] rst [5] = '{8'h01, 8'h03, 8'h01, 8'h02, 8'h03};
   int err_total = 0;
   int checked = 0;
   // ****************************************
   // Clock, design and board
   // ****************************************
   initial forever #2.5 sys_clk_i = ~sys_clk_i;
   gpio_port_pin_config #(.WIDTH(8), .IRQ_PIN_MASK(8'h40)) dut (.sys_clk_i, .rst_n_i,
      .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .stop_mode_i, .periph_out_i, .periph_oe_i,
      .debug_data_valid_i, .periph_in_o, .pin_i, .pin_o, .pin_oe_n_o, .pin_pullup_o,
      .pin_pulldown_o, .pin_input_en_o, .control_line_i, .control_line_oe_n_o,
      .control_line_in_o);
   board_pin_model board (.sys_clk_i, .pin_o, .pin_oe_n_o, .pin_pullup_o, .pin_pulldown_o,
      .control_line_oe_n_o, .pin_i, .control_line_i);
   // ****************************************
   // Bus tasks and checks
   // ****************************************
   task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      addr_i <= a;
      wdata_i <= {24'h00_0000, d};
      wr_i <= 1'b1;
      @(posedge sys_clk_i);
      wr_i <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge sys_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge sys_clk_i);
      rd_i <= 1'b0;
      #1 cmp("rdata", e, rdata_o);
   endtask
   task automatic end_sim;
      if (err_total == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Hang guard, far beyond the scripted run
   initial begin
      #100000;
      err_total++;
      end_sim();
   end
   initial begin
      repeat (4) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      #1 cmp("pullup", 8'h01, pin_pullup_o);
      cmp("pulldown", 8'h02, pin_pulldown_o);
      cmp("input_en", 8'h03, pin_input_en_o);
      cmp("oe_n", 8'hff, pin_oe_n_o);
      cmp("cl_oe_n", 1'b1, control_line_oe_n_o);
      for (int i = 0; i < 5; i++) rd(ofs[i], {24'h00_0000, rst[i]});
      rd(8'h10, 32'h0000_0000);
      // Reserved bits must stay clear
      for (int i = 1; i < 4; i++) wr(ofs[i], 8'hff);
      rd(8'h08, 32'h0000_007f);
      rd(8'h2c, 32'h0000_00fd);
      rd(8'h30, 32'h0000_0002);
      wr(8'h08, 8'h00);
      wr(8'h04, 8'h0f);
      wr(8'h38, 8'hff);
      wr(8'h00, 8'ha5);
      cmp("pin_o", 8'ha5, pin_o);
      cmp("oe_n", 8'hf0, pin_oe_n_o);
      repeat (2) @(posedge sys_clk_i);
      rd(8'h00, 32'h0000_00f5);
      wr(8'h38, 8'h0f);
      cmp("input_en", 8'h0f, pin_input_en_o);
      rd(8'h00, 32'h0000_0005);
      cmp("periph_in", 8'h05, periph_in_o);
      wr(8'h28, 8'h01);
      cmp("oe_n", 8'hf1, pin_oe_n_o);
      wr(8'h28, 8'h00);
      wr(8'h08, 8'h04);
      cmp("pin_o", 8'ha1, pin_o);
      cmp("oe_n", 8'hf4, pin_oe_n_o);
      @(posedge sys_clk_i) periph_oe_i <= 8'h45;
      #1 cmp("oe_n", 8'hf0, pin_oe_n_o);
      // Stop mode, drive enable still clear
      wr(8'h08, 8'h41);
      wr(8'h38, 8'h4f);
      wr(8'h04, 8'hff);
      @(posedge sys_clk_i) stop_mode_i <= 1'b1;
      #1 cmp("oe_n", 8'hff, pin_oe_n_o);
      cmp("input_en", 8'h40, pin_input_en_o);
      @(posedge sys_clk_i) debug_data_valid_i <= 1'b1;
      #1 cmp("oe_n", 8'hfe, pin_oe_n_o);
      wr(8'h40, 8'h03);
      cmp("oe_n", 8'h00, pin_oe_n_o);
      cmp("input_en", 8'h4f, pin_input_en_o);
      cmp("cl_oe_n", 1'b0, control_line_oe_n_o);
      repeat (2) @(posedge sys_clk_i);
      #1 cmp("cl_in", 1'b0, control_line_in_o);
      @(posedge sys_clk_i) debug_data_valid_i <= 1'b0;
      #1 cmp("oe_n", 8'h01, pin_oe_n_o);
      end_sim();
   end
endmodule
